// File: rtl/wsc_top.sv
`timescale 1ns/1ps
`include "wsc_cfg.svh"
module wsc_top #(
  parameter int DB_WIDTH = `WSC_DB_WIDTH
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_data,
  input  wire logic [3:0]  i_polarity,
  input  wire logic [3:0]  i_steering_enable,
  input  wire logic [3:0]  i_steer_data,
  input  wire logic        i_comparator_1_n,
  input  wire logic        i_comparator_2_n,
  input  wire logic        i_logic_cell_2_output_n,
  input  wire logic        i_pin_select_input_n,
  input  wire logic        i_irq_flag_clear,
  output logic             o_drive_out_a,
  output logic             o_drive_out_b,
  output logic             o_drive_out_c,
  output logic             o_drive_out_d,
  output logic             o_waveform_irq_flag,
  output logic             o_dead_band_load_pulse
);
  typedef struct packed {
    wsc_pkg::wsc_state_type st;
    wsc_pkg::wsc_load_type  ld;
    logic                   en;
    logic                   ld_req;
    logic [2:0]             mode;
    logic                   shutdown;
    logic                   ren;
    logic [1:0]             override_level_bd;
    logic [1:0]             override_level_ac;
    logic [3:0]             src_en;
    logic [DB_WIDTH-1:0]    rise_reg;
    logic [DB_WIDTH-1:0]    fall_reg;
    logic [DB_WIDTH-1:0]    rise_buf;
    logic [DB_WIDTH-1:0]    fall_buf;
    logic                   data_d;
    logic                   irq;
    logic                   load_pulse;
    logic                   fwd;
    logic [3:0]             outs;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
  } wsc_state_all_type;

  wsc_state_all_type s_r;
  wsc_state_all_type s_nxt;
  logic              db_high;
  logic              db_low;

  // Active-low source test; a disabled source never counts.
  function automatic logic src_active(input logic [3:0] en, input logic [3:0] lvl_n);
    src_active = |(en & ~lvl_n);
  endfunction

  function automatic logic ovr_level(input logic [1:0] code);
    ovr_level = (code == `WSC_OVR_HIGH);
  endfunction

  // The error answer must be known when the access begins, before any write lands.
  function automatic logic addr_ok(input logic [11:0] addr);
    case (addr)
      `WSC_ADDR_CTRL0,
      `WSC_ADDR_SDCTRL,
      `WSC_ADDR_SRCSEL,
      `WSC_ADDR_STATUS,
      `WSC_ADDR_DBRISE,
      `WSC_ADDR_DBFALL:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  endfunction

  wsc_dead_band #(
    .DB_WIDTH     (DB_WIDTH)
  ) u_db (
    .i_clk        (i_clk),
    .i_reset_n    (i_reset_n),
    .i_data       (i_data),
    .i_rise_count (s_r.rise_buf),
    .i_fall_count (s_r.fall_buf),
    .o_high       (db_high),
    .o_low        (db_low)
  );

  logic [3:0] src_lvl_n;
  assign src_lvl_n = {i_pin_select_input_n, i_logic_cell_2_output_n,
                      i_comparator_2_n, i_comparator_1_n};

  always_comb
  begin
    logic       ext_sd;
    logic       acc;
    logic       wr;
    logic       rd;
    logic       rise;
    logic       fall;
    logic       sd_set;
    logic       ld_set;
    logic [3:0] run;

    ext_sd = src_active(s_r.src_en, src_lvl_n);
    acc    = i_psel && i_penable && !s_r.pready;
    // Writes land on the completing edge, where the master sees pready high, so a
    // register never changes before the transfer that carries it has ended.
    wr     = i_psel && i_penable && i_pwrite && s_r.pready;
    rd     = acc && !i_pwrite;
    rise   = i_data && !s_r.data_d;
    fall   = !i_data && s_r.data_d;
    sd_set = 1'b0;
    ld_set = 1'b0;
    run    = 4'h0;
    s_nxt  = s_r;
    s_nxt.data_d     = i_data;
    s_nxt.load_pulse = 1'b0;
    // The answer follows the first access edge; the error flag and read data are
    // registered with it so that all three stand together for the master.
    s_nxt.pready     = acc;
    s_nxt.pslverr    = acc && !addr_ok(i_paddr);

    if (wr)
    begin
      case (i_paddr)
        `WSC_ADDR_CTRL0:
        begin
          // Load request only when enable was already one before this write.
          if (i_pwdata[`WSC_CTRL0_LD_BIT] && s_r.en)
            ld_set = 1'b1;
          s_nxt.en   = i_pwdata[`WSC_CTRL0_EN_BIT];
          s_nxt.mode = i_pwdata[2:0];
        end
        `WSC_ADDR_SDCTRL:
        begin
          if (i_pwdata[`WSC_SD_BIT])
            sd_set = 1'b1;
          else if (!ext_sd)
            s_nxt.shutdown = 1'b0;
          s_nxt.ren  = i_pwdata[`WSC_SD_REN_BIT];
          s_nxt.override_level_bd = i_pwdata[`WSC_SD_OVERRIDE_LEVEL_BD_HI:`WSC_SD_OVERRIDE_LEVEL_BD_LO];
          s_nxt.override_level_ac = i_pwdata[`WSC_SD_OVERRIDE_LEVEL_AC_HI:`WSC_SD_OVERRIDE_LEVEL_AC_LO];
        end
        `WSC_ADDR_SRCSEL:
          s_nxt.src_en = i_pwdata[3:0];
        `WSC_ADDR_DBRISE:
          s_nxt.rise_reg = i_pwdata[DB_WIDTH-1:0];
        `WSC_ADDR_DBFALL:
          s_nxt.fall_reg = i_pwdata[DB_WIDTH-1:0];
        // Status is read-only and stray addresses were refused when the access began.
        default:
        begin
        end
      endcase
    end

    // With the block disabled the count buffers follow the registers directly.
    if (!s_r.en)
    begin
      s_nxt.rise_buf = s_r.rise_reg;
      s_nxt.fall_buf = s_r.fall_reg;
      s_nxt.ld       = wsc_pkg::WSC_LD_IDLE;
      s_nxt.ld_req   = 1'b0;
    end
    else
    begin
      case (s_r.ld)
        wsc_pkg::WSC_LD_IDLE:
          if (s_r.ld_req)
            s_nxt.ld = wsc_pkg::WSC_LD_FALL;
        wsc_pkg::WSC_LD_FALL:
          if (fall)
            s_nxt.ld = wsc_pkg::WSC_LD_RISE;
        wsc_pkg::WSC_LD_RISE:
          if (rise)
          begin
            s_nxt.rise_buf   = s_r.rise_reg;
            s_nxt.fall_buf   = s_r.fall_reg;
            s_nxt.ld_req     = 1'b0;
            s_nxt.load_pulse = 1'b1;
            s_nxt.ld         = wsc_pkg::WSC_LD_IDLE;
          end
        default:
          s_nxt.ld = wsc_pkg::WSC_LD_IDLE;
      endcase
    end
    // A request written on the very edge that loads the buffers is kept for the
    // next load rather than lost under the hardware clear.
    if (ld_set)
      s_nxt.ld_req = 1'b1;

    if (ext_sd)
      sd_set = 1'b1;
    if (sd_set)
      s_nxt.shutdown = 1'b1;
    else if (s_r.shutdown && s_r.ren && !ext_sd && rise)
      s_nxt.shutdown = 1'b0;
    // Only the rise of the shutdown bit is an event: a source that merely stays
    // active must not hold the flag up against a software clear.
    if (sd_set && !s_r.shutdown)
      s_nxt.irq = 1'b1;
    else if (i_irq_flag_clear)
      s_nxt.irq = 1'b0;

    // Direction follows the mode only at a data rise, so a bridge never swaps
    // its static legs in the middle of a pulse.
    if (rise && s_r.mode == wsc_pkg::WSC_MODE_FWD_BRIDGE)
      s_nxt.fwd = 1'b1;
    else if (rise && s_r.mode == wsc_pkg::WSC_MODE_REV_BRIDGE)
      s_nxt.fwd = 1'b0;

    case (s_r.st)
      // Enabling lands in shutdown, so the outputs sit at the override levels
      // until software or auto-restart lets the first data rise through.
      wsc_pkg::WSC_ST_OFF:
        if (s_r.en)
        begin
          s_nxt.st       = wsc_pkg::WSC_ST_SHUT;
          s_nxt.shutdown = 1'b1;
        end
      wsc_pkg::WSC_ST_SHUT:
        if (!s_r.en)
          s_nxt.st = wsc_pkg::WSC_ST_OFF;
        else if (!s_r.shutdown && rise)
          s_nxt.st = wsc_pkg::WSC_ST_RUN;
      wsc_pkg::WSC_ST_RUN:
        if (!s_r.en)
          s_nxt.st = wsc_pkg::WSC_ST_OFF;
        else if (s_r.shutdown || sd_set)
          s_nxt.st = wsc_pkg::WSC_ST_SHUT;
      default:
        s_nxt.st = wsc_pkg::WSC_ST_OFF;
    endcase

    case (wsc_pkg::wsc_mode_type'(s_r.mode))
      wsc_pkg::WSC_MODE_ASYNC_STEER,
      wsc_pkg::WSC_MODE_SYNC_STEER:
        for (int k = 0; k < 4; k++)
          run[k] = i_steering_enable[k] ? i_data : i_steer_data[k];
      wsc_pkg::WSC_MODE_FWD_BRIDGE,
      wsc_pkg::WSC_MODE_REV_BRIDGE:
        run = s_nxt.fwd ? {i_data, 1'b0, 1'b0, 1'b1} : {1'b0, 1'b1, i_data, 1'b0};
      wsc_pkg::WSC_MODE_HALF_BRIDGE:
        run = {db_low, db_high, db_low, db_high};
      wsc_pkg::WSC_MODE_PUSH_PULL:
        run = {i_data, ~i_data, i_data, ~i_data};
      default:
        run = 4'h0;
    endcase
    run = run ^ i_polarity;

    // Override bypasses polarity so the safe levels stay what software programmed.
    if (s_nxt.st != wsc_pkg::WSC_ST_RUN || s_nxt.shutdown)
    begin
      s_nxt.outs[0] = ovr_level(s_r.override_level_ac);
      s_nxt.outs[2] = ovr_level(s_r.override_level_ac);
      s_nxt.outs[1] = ovr_level(s_r.override_level_bd);
      s_nxt.outs[3] = ovr_level(s_r.override_level_bd);
    end
    else
      s_nxt.outs = run;

    // Read data is taken at the first access edge and held until the next read.
    if (rd)
    begin
      case (i_paddr)
        `WSC_ADDR_CTRL0:
          s_nxt.prdata = {24'h0, s_r.en, s_r.ld_req, 3'h0, s_r.mode};
        `WSC_ADDR_SDCTRL:
          s_nxt.prdata = {24'h0, s_r.shutdown, s_r.ren, s_r.override_level_bd, s_r.override_level_ac, 2'h0};
        `WSC_ADDR_SRCSEL:
          s_nxt.prdata = {28'h0, s_r.src_en};
        `WSC_ADDR_STATUS:
          s_nxt.prdata = {28'h0, s_r.st == wsc_pkg::WSC_ST_RUN, s_r.irq, ext_sd, i_data};
        `WSC_ADDR_DBRISE:
          s_nxt.prdata = {{(32-DB_WIDTH){1'b0}}, s_r.rise_reg};
        `WSC_ADDR_DBFALL:
          s_nxt.prdata = {{(32-DB_WIDTH){1'b0}}, s_r.fall_reg};
        default:
          s_nxt.prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s_r          <= '0;
      s_r.st       <= wsc_pkg::WSC_ST_OFF;
      s_r.ld       <= wsc_pkg::WSC_LD_IDLE;
      // Both override fields leave reset at code one, which drives the outputs high.
      s_r.override_level_bd     <= 2'h1;
      s_r.override_level_ac     <= 2'h1;
      s_r.src_en   <= `WSC_SRC_RESET;
    end
    else
      s_r <= s_nxt;
  end

  assign o_prdata               = s_r.prdata;
  assign o_pready               = s_r.pready;
  assign o_pslverr              = s_r.pslverr;
  assign o_drive_out_a          = s_r.outs[0];
  assign o_drive_out_b          = s_r.outs[1];
  assign o_drive_out_c          = s_r.outs[2];
  assign o_drive_out_d          = s_r.outs[3];
  assign o_waveform_irq_flag    = s_r.irq;
  assign o_dead_band_load_pulse = s_r.load_pulse;
endmodule // wsc_top

// File: rtl/wsc_cfg.svh
`ifndef WSC_CFG_SVH
`define WSC_CFG_SVH
// Register byte addresses on the APB bus.
`define WSC_ADDR_CTRL0     12'h000
`define WSC_ADDR_SDCTRL    12'h004
`define WSC_ADDR_SRCSEL    12'h008
`define WSC_ADDR_STATUS    12'h00c
`define WSC_ADDR_DBRISE    12'h010
`define WSC_ADDR_DBFALL    12'h014
// Control register 0 fields.
`define WSC_CTRL0_EN_BIT   7
`define WSC_CTRL0_LD_BIT   6
`define WSC_CTRL0_RESET    8'h00
// Shutdown control register fields.
`define WSC_SD_BIT         7
`define WSC_SD_REN_BIT     6
`define WSC_SD_OVERRIDE_LEVEL_BD_HI     5
`define WSC_SD_OVERRIDE_LEVEL_BD_LO     4
`define WSC_SD_OVERRIDE_LEVEL_AC_HI     3
`define WSC_SD_OVERRIDE_LEVEL_AC_LO     2
`define WSC_SD_RESET       8'h14
// Source select: bit0 comparator 1, bit1 comparator 2, bit2 logic cell 2, bit3 pin input.
`define WSC_SRC_RESET      4'h0
// Override level codes.
`define WSC_OVR_LOW        2'h0
`define WSC_OVR_HIGH       2'h1
`define WSC_DB_WIDTH       6
`endif

// File: rtl/wsc_pkg.sv
package wsc_pkg;
  typedef enum logic [2:0]
  {
    WSC_ST_OFF   = 3'b001,
    WSC_ST_SHUT  = 3'b010,
    WSC_ST_RUN   = 3'b100
  } wsc_state_type;
  typedef enum logic [2:0]
  {
    WSC_MODE_ASYNC_STEER = 3'h0,
    WSC_MODE_SYNC_STEER  = 3'h1,
    WSC_MODE_FWD_BRIDGE  = 3'h2,
    WSC_MODE_REV_BRIDGE  = 3'h3,
    WSC_MODE_HALF_BRIDGE = 3'h4,
    WSC_MODE_PUSH_PULL   = 3'h5
  } wsc_mode_type;
  typedef enum logic [2:0]
  {
    WSC_LD_IDLE = 3'b001,
    WSC_LD_FALL = 3'b010,
    WSC_LD_RISE = 3'b100
  } wsc_load_type;
endpackage

// File: rtl/wsc_dead_band.sv
`timescale 1ns/1ps
`include "wsc_cfg.svh"
// Dead band after each data edge: counts from zero to the loaded count.
module wsc_dead_band #(
  parameter int DB_WIDTH = `WSC_DB_WIDTH
) (
  input  wire logic                i_clk,
  input  wire logic                i_reset_n,
  input  wire logic                i_data,
  input  wire logic [DB_WIDTH-1:0] i_rise_count,
  input  wire logic [DB_WIDTH-1:0] i_fall_count,
  output logic                     o_high,
  output logic                     o_low
);
  typedef struct packed {
    logic                data;
    logic [DB_WIDTH-1:0] cnt;
    logic                high;
    logic                low;
  } wsc_db_type;

  wsc_db_type s_r;
  wsc_db_type s_nxt;

  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.data = i_data;
    if (i_data != s_r.data)
    begin
      // A reversal before the count ends restarts it, so nothing reaches the output.
      s_nxt.cnt  = '0;
      s_nxt.high = 1'b0;
      s_nxt.low  = 1'b0;
      if (i_data && i_rise_count == '0)
        s_nxt.high = 1'b1;
      if (!i_data && i_fall_count == '0)
        s_nxt.low = 1'b1;
    end
    else if (i_data && !s_r.high)
    begin
      s_nxt.cnt = s_r.cnt + 1'b1;
      if (s_nxt.cnt >= i_rise_count)
        s_nxt.high = 1'b1;
    end
    else if (!i_data && !s_r.low)
    begin
      s_nxt.cnt = s_r.cnt + 1'b1;
      if (s_nxt.cnt >= i_fall_count)
        s_nxt.low = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign o_high = s_r.high;
  assign o_low  = s_r.low;
endmodule // wsc_dead_band

// File: tb/wsc_top_asserts.sv
`timescale 1ns/1ps
module wsc_top_asserts #(
  parameter int DB_WIDTH = 6
) (
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        i_comparator_1_n,
  input wire logic        i_comparator_2_n,
  input wire logic        i_logic_cell_2_output_n,
  input wire logic        i_pin_select_input_n,
  input wire logic        i_irq_flag_clear,
  input wire logic        o_drive_out_a,
  input wire logic        o_drive_out_b,
  input wire logic        o_drive_out_c,
  input wire logic        o_drive_out_d,
  input wire logic        o_waveform_irq_flag,
  input wire logic        o_dead_band_load_pulse
);
  logic [3:0] src_r;
  logic [3:0] ovr_r;
  logic       en_r;
  logic       hold;
  logic [3:0] ov;
  // The shadows follow completed writes, in step with the design's own registers.
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      src_r <= 4'h0;
      ovr_r <= 4'h5;
      en_r  <= 1'b0;
    end
    else if (i_psel && i_penable && i_pwrite && o_pready)
    begin
      if (i_paddr == 12'h008)
        src_r <= i_pwdata[3:0];
      if (i_paddr == 12'h004)
        ovr_r <= i_pwdata[5:2];
      if (i_paddr == 12'h000)
        en_r <= i_pwdata[7];
    end
  end
  assign hold = en_r && |(src_r & ~{i_pin_select_input_n, i_logic_cell_2_output_n,
                                    i_comparator_2_n, i_comparator_1_n});
  assign ov = {ovr_r[3:2] == 2'h1, ovr_r[1:0] == 2'h1, ovr_r[3:2] == 2'h1, ovr_r[1:0] == 2'h1};
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  ready_timing_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("pready late");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  upper_zero_a: assert property (o_pready && !i_pwrite |-> o_prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  ctrl_gap_a: assert property (
    o_pready && !i_pwrite && i_paddr == 12'h000 |-> o_prdata[5:3] == 3'h0)
    else $error("control gap bits set");
  unmapped_err_a: assert property (o_pready && i_paddr > 12'h014 |-> o_pslverr)
    else $error("unmapped access accepted");
  irq_sticky_a: assert property (
    o_waveform_irq_flag && !i_irq_flag_clear |=> o_waveform_irq_flag)
    else $error("irq flag dropped");
  override_hold_a: assert property (
    hold [*3] |-> {o_drive_out_d, o_drive_out_c, o_drive_out_b, o_drive_out_a} == ov)
    else $error("override levels not driven");
  load_single_a: assert property (o_dead_band_load_pulse |=> !o_dead_band_load_pulse)
    else $error("load pulse too long");
endmodule // wsc_top_asserts
bind wsc_top wsc_top_asserts #(.DB_WIDTH(DB_WIDTH)) i_wsc_top_asserts (
  .i_clk, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
  .o_pready, .o_pslverr, .i_comparator_1_n, .i_comparator_2_n, .i_logic_cell_2_output_n,
  .i_pin_select_input_n, .i_irq_flag_clear, .o_drive_out_a, .o_drive_out_b, .o_drive_out_c,
  .o_drive_out_d, .o_waveform_irq_flag, .o_dead_band_load_pulse
);

// File: tb/wsc_src_model.sv
`timescale 1ns/1ps
module wsc_src_model (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_run,
  input  wire logic [3:0] i_shut,
  output logic            o_data,
  output logic [3:0]      o_src_n
);
  logic [2:0] cnt_r;
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cnt_r  <= 3'h0;
      o_data <= 1'b0;
    end
    else if (i_run)
    begin
      cnt_r <= cnt_r + 3'h1;
      if (cnt_r == 3'h7)
        o_data <= ~o_data;
    end
  end
  // A fault holds its line low for as long as it lasts, never as a pulse.
  assign o_src_n = ~i_shut;
endmodule // wsc_src_model

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        i_psel = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic [3:0]  i_polarity = 4'h0;
  logic        i_irq_flag_clear = 1'b0;
  logic        run = 1'b0;
  logic [3:0]  shut = 4'h0;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic        data;
  logic [3:0]  src_n;
  logic [3:0]  outs;
  logic        irq;
  logic        ld_pulse;
  logic [31:0] rdq;
  logic        errq;
  int          n_errors = 0;
  int          checks_done = 0;
  wsc_top i_wsc_top (
    .i_clk, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .o_pready, .o_pslverr, .i_data(data), .i_polarity, .i_steering_enable(4'h0),
    .i_steer_data(4'h0), .i_comparator_1_n(src_n[0]), .i_comparator_2_n(src_n[1]),
    .i_logic_cell_2_output_n(src_n[2]), .i_pin_select_input_n(src_n[3]), .i_irq_flag_clear,
    .o_drive_out_a(outs[0]), .o_drive_out_b(outs[1]), .o_drive_out_c(outs[2]),
    .o_drive_out_d(outs[3]), .o_waveform_irq_flag(irq), .o_dead_band_load_pulse(ld_pulse)
  );
  wsc_src_model i_wsc_src_model (
    .i_clk, .i_reset_n, .i_run(run), .i_shut(shut), .o_data(data), .o_src_n(src_n)
  );
  initial
  begin
    forever #4 i_clk = ~i_clk;
  end
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // An idle edge first, so psel is never lowered and raised in one time step.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (o_pready !== 1'b1 && n < 50);
    ck(n < 50, 1'b1);
    rdq = o_prdata;
    errq = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wt(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    int k;
    for (k = 0; k < 60; k++)
    begin
      rd(a);
      if ((rdq & m) === e)
        break;
    end
    ck(rdq & m, e);
  endtask
  task automatic clr_irq;
    i_irq_flag_clear <= 1'b1;
    @(posedge i_clk);
    i_irq_flag_clear <= 1'b0;
    repeat (2) @(posedge i_clk);
    ck(irq, 1'b0);
  endtask
  task automatic t_regs;
    rd(12'h000);
    ck(rdq, 32'h0);
    rd(12'h004);
    ck(rdq, 32'h14);
    rd(12'h008);
    ck(rdq, 32'h0);
    rd(12'h100);
    ck(errq, 1'b1);
  endtask
  task automatic t_enable;
    int m;
    wr(12'h004, 32'h10);
    wr(12'h000, 32'h04);
    wr(12'h000, 32'h84);
    rd(12'h004);
    ck(rdq[7], 1'b1);
    ck(outs, 4'ha);
    for (m = 0; m < 6; m++)
    begin
      wr(12'h000, 32'hb8 | m);
      rd(12'h000);
      ck(rdq, 32'h80 | m);
    end
    wr(12'h000, 32'h84);
  endtask
  task automatic t_soft;
    run <= 1'b1;
    wr(12'h004, 32'h10);
    wt(12'h00c, 32'h8, 32'h8);
    rd(12'h004);
    ck(rdq[7], 1'b0);
    clr_irq;
    wr(12'h004, 32'h90);
    repeat (2) @(posedge i_clk);
    ck(outs, 4'ha);
    ck(irq, 1'b1);
    clr_irq;
    wr(12'h004, 32'h10);
  endtask
  task automatic t_ext;
    int s;
    i_polarity <= 4'hf;
    for (s = 0; s < 4; s++)
    begin
      shut <= 4'h1 << s;
      wr(12'h008, 32'h1 << s);
      repeat (3) @(posedge i_clk);
      ck(outs, 4'ha);
      ck(irq, 1'b1);
      clr_irq;
      wr(12'h004, 32'h10);
      rd(12'h004);
      ck(rdq[7], 1'b1);
      if (s == 3)
        wr(12'h008, 32'h0);
      else
        shut <= 4'h0;
      wr(12'h004, 32'h10);
      rd(12'h004);
      ck(rdq[7], 1'b0);
      shut <= 4'h0;
      wr(12'h008, 32'h0);
    end
  endtask
  task automatic t_auto;
    wr(12'h004, 32'hd0);
    wt(12'h004, 32'h80, 32'h0);
    wt(12'h00c, 32'h8, 32'h8);
    shut <= 4'h2;
    wr(12'h008, 32'h2);
    rd(12'h004);
    ck(rdq[7], 1'b1);
    shut <= 4'h0;
    wt(12'h004, 32'h80, 32'h0);
    wr(12'h008, 32'h0);
  endtask
  task automatic t_load;
    int n;
    wr(12'h000, 32'hc4);
    n = 0;
    while (ld_pulse !== 1'b1 && n < 100)
    begin
      @(posedge i_clk);
      n++;
    end
    ck(n < 100, 1'b1);
    rd(12'h000);
    ck(rdq, 32'h84);
    wr(12'h000, 32'h04);
    wr(12'h000, 32'hc4);
    rd(12'h000);
    ck(rdq, 32'h84);
  endtask
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_regs;
    t_enable;
    t_soft;
    t_ext;
    t_auto;
    t_load;
    conclude;
  end
  initial
  begin
    #200000;
    n_errors++;
    conclude;
  end
endmodule // tb
